//--- hw/bridge_adc_measurement_sequencer.v
// Function
// - Mux steps bridge, temperature and offset in a configured fixed order.
// - After reset a five-conversion startup routine runs before normal cycling.
// - Configuration selects 13 or 14 bit resolution, setting conversion length.
// - Each conversion lasts 2^(r+1) oscillator cycles.
// - Result equals 2^r times input ratio minus the configured range shift.
// - Digital result within converter resolution; analog code is 12 bits.
// - Configuration picks internal or external temperature sensor.
// - Offset is measured and delivered for digital removal, no analog trim.
// - Gain is one of nine steps from 105 down to 2.8.
// - Reference select bit set to 1 picks the analog supply reference.
`timescale 1ns/1ps
`include "bridge_seq_defines.vh"

module bridge_adc_measurement_sequencer #(
   parameter [15:0] CONV_LEN13 = `CONV_LEN13_DEF,
   parameter [15:0] CONV_LEN14 = `CONV_LEN14_DEF
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        modulatorBit,
   input  wire        resultAck,
   output reg  [1:0]  muxSelect,
   output reg  [3:0]  gainCode,
   output reg         refSelect,
   output reg         resolution14,
   output reg         convActive,
   output reg  [15:0] resultData,
   output reg  [1:0]  resultSource,
   output reg         resultValid,
   output reg  [11:0] analogCode,
   output reg         startupDone
);

   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_CONV    = 2'h1;
   localparam [1:0] ST_DELIVER = 2'h2;

   reg [`CFG_WIDTH-1:0] config_q;
   reg                  run_q;
   reg                  restart_q;
   reg [1:0]            state_q;
   reg [15:0]           cycleCnt_q;
   reg [15:0]           convLen_q;
   reg [15:0]           onesCnt_q;
   reg [2:0]            stepCnt_q;
   reg [2:0]            bridgeCnt_q;
   reg                  specialTemp_q;
   reg                  inStartup_q;

   wire [1:0]  rangeShift   = config_q[`CFG_SHIFT_HI:`CFG_SHIFT_LO];
   wire [2:0]  bridgePerSpc = config_q[`CFG_BPS_HI:`CFG_BPS_LO];
   wire        wbReq        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wbWrite      = wbReq & wb_we_i;

   function [1:0] tempSource;
      input ext;
      begin
         tempSource = ext ? `SRC_TEMP_EXT : `SRC_TEMP_INT;
      end
   endfunction

   // Startup covers every channel the conditioning formula needs
   function [1:0] startupSource;
      input [2:0] step;
      input       ext;
      begin
         case (step)
            3'h0: begin
               startupSource = `SRC_OFFSET;
            end
            3'h1: begin
               startupSource = tempSource(ext);
            end
            3'h2: begin
               startupSource = `SRC_BRIDGE;
            end
            3'h3: begin
               // Second offset sample brackets the first bridge reading
               startupSource = `SRC_OFFSET;
            end
            default: begin
               startupSource = `SRC_BRIDGE;
            end
         endcase
      end
   endfunction

   function [31:0] byteMerge;
      input [31:0] old;
      input [31:0] wdat;
      input [3:0]  sel;
      integer      i;
      begin
         byteMerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               byteMerge[i*8 +: 8] = wdat[i*8 +: 8];
            end
         end
      end
   endfunction

   // Relative count after range shift; full scale is half the conv length
   wire [15:0] fullScale   = {1'b0, convLen_q[15:1]};
   wire [2:0]  shiftAmt    = `RANGE_SHIFT_BASE - {1'b0, rangeShift};
   wire [15:0] rangeOffset = fullScale >> shiftAmt;
   wire [15:0] onesNext    = onesCnt_q + {15'h0000, modulatorBit};
   wire [15:0] relCount    = onesNext - rangeOffset;

   // Analog path keeps the top 12 bits of the non-negative range
   wire [15:0] dacShifted  = resolution14 ? (relCount >> 2) : (relCount >> 1);
   wire        dacNeg      = relCount[15];
   wire        dacOver     = |dacShifted[15:`DAC_WIDTH];

   // Next channel, from the startup routine or the normal cycle
   reg [1:0] nextSource;
   always @* begin
      nextSource = `SRC_BRIDGE;
      if (inStartup_q) begin
         nextSource = startupSource(stepCnt_q, config_q[`CFG_EXTTEMP]);
      end else if (bridgeCnt_q < bridgePerSpc + 3'h1 &&
                   bridgeCnt_q != 3'h7) begin
         nextSource = `SRC_BRIDGE;
      end else if (specialTemp_q) begin
         nextSource = tempSource(config_q[`CFG_EXTTEMP]);
      end else begin
         nextSource = `SRC_OFFSET;
      end
   end

   wire convDone  = (state_q == ST_CONV) && (cycleCnt_q == convLen_q - 16'h1);
   wire startConv = (state_q == ST_IDLE) && (run_q || inStartup_q);

   // Register bus: ack one cycle after the request, unmapped reads zero
   always @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= 32'h0000_0000;
         if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
               `REG_CONFIG: begin
                  wb_dat_o <= {19'h0_0000, config_q};
               end
               `REG_CONTROL: begin
                  // Restart self clears, so only run reads back
                  wb_dat_o <= {31'h0000_0000, run_q};
               end
               `REG_STATUS: begin
                  wb_dat_o <= {25'h000_0000, resultSource, state_q,
                               resultValid, convActive, startupDone};
               end
               `REG_RESULT: begin
                  wb_dat_o <= {14'h0000, resultSource, resultData};
               end
               default: begin
                  wb_dat_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Configuration and control writes
   reg [31:0] cfgMerged;
   always @* begin
      cfgMerged = byteMerge({19'h0_0000, config_q}, wb_dat_i, wb_sel_i);
   end

   always @(posedge clk) begin
      if (rst) begin
         config_q  <= `CFG_RESET;
         run_q     <= 1'b1;
         restart_q <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (wbWrite && wb_adr_i == `REG_CONFIG) begin
            config_q[`CFG_GAIN_LO-1:0] <= cfgMerged[`CFG_GAIN_LO-1:0];
            config_q[`CFG_WIDTH-1:`CFG_REFSEL] <=
               cfgMerged[`CFG_WIDTH-1:`CFG_REFSEL];
            // Undefined gain codes are dropped, keeping the last valid step
            if (cfgMerged[`CFG_GAIN_HI:`CFG_GAIN_LO] <= `GAIN_MAX_CODE) begin
               config_q[`CFG_GAIN_HI:`CFG_GAIN_LO] <=
                  cfgMerged[`CFG_GAIN_HI:`CFG_GAIN_LO];
            end
         end
         if (wbWrite && wb_adr_i == `REG_CONTROL && wb_sel_i[0]) begin
            run_q     <= wb_dat_i[`CTL_RUN];
            restart_q <= wb_dat_i[`CTL_RESTART];
         end
      end
   end

   // Front-end settings follow the configuration directly
   always @(posedge clk) begin
      if (rst) begin
         gainCode  <= 4'h0;
         refSelect <= 1'b0;
      end else begin
         gainCode  <= config_q[`CFG_GAIN_HI:`CFG_GAIN_LO];
         refSelect <= config_q[`CFG_REFSEL];
      end
   end

   // Measurement sequencer
   always @(posedge clk) begin
      if (rst) begin
         state_q       <= ST_IDLE;
         cycleCnt_q    <= 16'h0000;
         convLen_q     <= CONV_LEN13;
         onesCnt_q     <= 16'h0000;
         stepCnt_q     <= 3'h0;
         bridgeCnt_q   <= 3'h0;
         specialTemp_q <= 1'b0;
         inStartup_q   <= 1'b1;
         startupDone   <= 1'b0;
         muxSelect     <= `SRC_OFFSET;
         resolution14  <= 1'b0;
         convActive    <= 1'b0;
         resultData    <= 16'h0000;
         resultSource  <= `SRC_BRIDGE;
         resultValid   <= 1'b0;
         analogCode    <= 12'h000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (restart_q) begin
                  inStartup_q <= 1'b1;
                  startupDone <= 1'b0;
                  stepCnt_q   <= 3'h0;
               end else if (startConv) begin
                  // Resolution is latched so a config write cannot
                  // stretch a conversion already under way
                  resolution14 <= config_q[`CFG_RES14];
                  convLen_q    <= config_q[`CFG_RES14] ?
                                  CONV_LEN14 : CONV_LEN13;
                  muxSelect    <= nextSource;
                  cycleCnt_q   <= 16'h0000;
                  onesCnt_q    <= 16'h0000;
                  convActive   <= 1'b1;
                  state_q      <= ST_CONV;
               end
            end
            ST_CONV: begin
               cycleCnt_q <= cycleCnt_q + 16'h1;
               // Modulator is sampled at half the oscillator rate
               if (cycleCnt_q[0]) begin
                  onesCnt_q <= onesNext;
               end
               if (convDone) begin
                  convActive   <= 1'b0;
                  resultData   <= relCount;
                  resultSource <= muxSelect;
                  resultValid  <= 1'b1;
                  if (dacNeg) begin
                     analogCode <= 12'h000;
                  end else if (dacOver) begin
                     analogCode <= `DAC_MAX;
                  end else begin
                     analogCode <= dacShifted[`DAC_WIDTH-1:0];
                  end
                  state_q <= ST_DELIVER;
               end
            end
            ST_DELIVER: begin
               // Held until the controller takes it, stalling the cycle
               if (resultAck) begin
                  resultValid <= 1'b0;
                  state_q     <= ST_IDLE;
                  if (inStartup_q) begin
                     if (stepCnt_q == `STARTUP_CONVS - 3'h1) begin
                        inStartup_q   <= 1'b0;
                        startupDone   <= 1'b1;
                        bridgeCnt_q   <= 3'h0;
                        specialTemp_q <= ~config_q[`CFG_OFFFIRST];
                     end else begin
                        stepCnt_q <= stepCnt_q + 3'h1;
                     end
                  end else if (resultSource == `SRC_BRIDGE) begin
                     bridgeCnt_q <= bridgeCnt_q + 3'h1;
                  end else begin
                     bridgeCnt_q   <= 3'h0;
                     specialTemp_q <= ~specialTemp_q;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

//--- hw/bridge_seq_defines.vh
`ifndef BRIDGE_SEQ_DEFINES_VH
`define BRIDGE_SEQ_DEFINES_VH

// Register byte offsets (word aligned)
`define REG_CONFIG        8'h00
`define REG_CONTROL       8'h04
`define REG_STATUS        8'h08
`define REG_RESULT        8'h0C

// Configuration register fields
`define CFG_RES14         0
`define CFG_SHIFT_LO      1
`define CFG_SHIFT_HI      2
`define CFG_EXTTEMP       3
`define CFG_GAIN_LO       4
`define CFG_GAIN_HI       7
`define CFG_REFSEL        8
`define CFG_BPS_LO        9
`define CFG_BPS_HI        11
`define CFG_OFFFIRST      12
`define CFG_WIDTH         13
`define CFG_RESET         13'h0_000

// Control register fields
`define CTL_RUN           0
`define CTL_RESTART       1

// Input multiplexer codes, also the result source tag
`define SRC_BRIDGE        2'h0
`define SRC_TEMP_INT      2'h1
`define SRC_TEMP_EXT      2'h2
`define SRC_OFFSET        2'h3

// Amplifier gain steps: code 0 is gain 105 down to code 8 is gain 2.8
`define GAIN_MAX_CODE     4'h8

// Conversion length in oscillator cycles, 2^(r+1)
`define CONV_LEN13_DEF    16'h4000
`define CONV_LEN14_DEF    16'h8000

// Startup routine length in conversions
`define STARTUP_CONVS     3'h5
`define RANGE_SHIFT_BASE  3'h4

// Result layout
`define RES_WIDTH         16
`define DAC_WIDTH         12
`define DAC_MAX           12'hFFF

`endif

//--- tb/calib_ctrl_model.sv
`timescale 1ns/1ps
module calib_ctrl_model (
   input  logic       clk,
   input  logic       rst,
   input  logic       resultValid,
   input  logic [1:0] ackDelay,
   output logic       modulatorBit,
   output logic       resultAck
);
   logic [3:0] waitCnt_q;
   // Full-scale modulator keeps every count exactly predictable
   assign modulatorBit = 1'b1;
   always_ff @(posedge clk) begin
      if (rst) begin
         waitCnt_q <= 4'h0;
         resultAck <= 1'b0;
      end else begin
         waitCnt_q <= resultValid ? waitCnt_q + 4'h1 : 4'h0;
         resultAck <= resultValid && !resultAck &&
            waitCnt_q >= {2'b00, ackDelay};
      end
   end
endmodule

//--- tb/seq_asserts.sv
`timescale 1ns/1ps
module seq_asserts #(
   parameter [15:0] CONV_LEN13 = 16'h4000,
   parameter [15:0] CONV_LEN14 = 16'h8000
) (
   input logic        clk,
   input logic        rst,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_ack_o,
   input logic [31:0] wb_dat_o,
   input logic        resultAck,
   input logic [1:0]  muxSelect,
   input logic [3:0]  gainCode,
   input logic        resolution14,
   input logic        convActive,
   input logic [15:0] resultData,
   input logic [1:0]  resultSource,
   input logic        resultValid,
   input logic [11:0] analogCode
);
   logic [15:0] runLen_q;
   logic [11:0] expAnalog;
   always_ff @(posedge clk) begin
      if (rst || !convActive) runLen_q <= 16'h0000;
      else runLen_q <= runLen_q + 16'h0001;
   end
   // Negative counts clip low, counts past full scale clip high
   always_comb begin
      if (resultData[15]) expAnalog = 12'h000;
      else if (resultData[14] || (!resolution14 && resultData[13]))
         expAnalog = 12'hFFF;
      else expAnalog = resolution14 ? resultData[13:2] : resultData[12:1];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o) else $error("request not answered");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_conv_length: assert property ($fell(convActive) |-> resultValid &&
      runLen_q == (resolution14 ? CONV_LEN14 : CONV_LEN13))
      else $error("conversion length wrong");
   a_result_hold: assert property (resultValid && !resultAck |=>
      resultValid && $stable(resultData) && $stable(resultSource))
      else $error("result dropped early");
   a_no_overlap: assert property (resultValid |-> !convActive)
      else $error("conversion during delivery");
   a_ack_release: assert property (resultValid && resultAck |=>
      !resultValid ##1 !resultValid) else $error("result not released");
   a_mux_steady: assert property (convActive && $past(convActive) |->
      $stable(muxSelect)) else $error("mux moved mid conversion");
   a_res_latched: assert property (convActive && $past(convActive) |->
      $stable(resolution14)) else $error("resolution moved");
   a_analog_clip: assert property (resultValid |->
      analogCode == expAnalog) else $error("analog code wrong");
   a_gain_range: assert property (gainCode <= 4'h8)
      else $error("gain code out of range");
endmodule
bind bridge_adc_measurement_sequencer seq_asserts #(
   .CONV_LEN13(CONV_LEN13),
   .CONV_LEN14(CONV_LEN14)
) chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .resultAck,
   .muxSelect, .gainCode, .resolution14, .convActive, .resultData,
   .resultSource, .resultValid, .analogCode);

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "bridge_seq_defines.vh"
module testbench;
   logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, modulatorBit, resultAck;
   logic        refSelect, resolution14, convActive, resultValid, startupDone;
   logic        rvPrev = 1'b0;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel, gainCode;
   logic [31:0] wbDat, wbRdat, rd, r;
   logic [1:0]  ackDelay, muxSelect, resultSource;
   logic [15:0] resultData;
   logic [11:0] analogCode;
   logic [17:0] e;
   logic [17:0] expQ[$];
   int          error_cnt = 0, samples_checked = 0, seed = 22050, n;
   bridge_adc_measurement_sequencer #(.CONV_LEN13(16'h0020),
      .CONV_LEN14(16'h0040)) uut (.clk, .rst, .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck), .modulatorBit,
      .resultAck, .muxSelect, .gainCode, .refSelect, .resolution14,
      .convActive, .resultData, .resultSource, .resultValid, .analogCode,
      .startupDone);
   calib_ctrl_model ctrl (.clk, .rst, .resultValid, .ackDelay, .modulatorBit,
      .resultAck);
   task check(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task end_of_test;
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int k;
      wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w;
      wbAdr <= a; wbDat <= d; wbSel <= s;
      k = 0;
      do begin @(posedge clk); k++; end while (wbAck !== 1'b1 && k < 50);
      if (k >= 50) error_cnt++;
      rd = wbRdat;
      wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [15:0] expData(input logic [15:0] len, int rs);
      return (len >> 1) - ((len >> 1) >> (4 - rs));
   endfunction
   // Source codes packed two bits each, first result in the low bits
   task push(input int cnt, input logic [31:0] codes, input logic [15:0] d);
      for (int i = 0; i < cnt; i++) expQ.push_back({codes[2*i+:2], d});
   endtask
   task wait_empty;
      while (expQ.size() > 0) @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      ackDelay <= 2'($random(seed));
      if (!rst && resultValid === 1'b1 && !rvPrev && expQ.size() > 0) begin
         e = expQ.pop_front();
         check("source", 32'(e[17:16]), 32'(resultSource));
         check("data", 32'(e[15:0]), 32'(resultData));
         check("mux", 32'(e[17:16]), 32'(muxSelect));
      end
      rvPrev <= (resultValid === 1'b1);
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      end_of_test;
   end
   initial begin
      rst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; ackDelay = 2'h0;
      wbAdr = 8'h00; wbSel = 4'h0; wbDat = 32'h0000_0000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      push(9, 32'h0003_10C7, expData(16'h0020, 0));
      wb(1'b0, `REG_CONFIG, 32'h0000_0000, 4'hF);
      check("config", 32'h0000_0000, rd);
      wb(1'b0, `REG_CONTROL, 32'h0000_0000, 4'hF);
      check("control", 32'h0000_0001, rd);
      wb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
      check("unmapped", 32'h0000_0000, rd);
      check("startupDone", 32'h0, 32'(startupDone));
      wait_empty;
      check("startupDone", 32'h1, 32'(startupDone));
      check("refSelect", 32'h0, 32'(refSelect));
      wb(1'b1, `REG_CONTROL, 32'h0000_0000, 4'h1);
      n = 0;
      while (n < 2) begin
         @(posedge clk);
         n = (!convActive && !resultValid) ? n + 1 : 0;
      end
      r = $random(seed);
      wb(1'b1, `REG_CONFIG, {r[31:13], 13'h139F}, 4'hF);
      wb(1'b0, `REG_CONFIG, 32'h0000_0000, 4'hF);
      check("config", 32'h0000_130F, rd);
      wb(1'b1, `REG_CONFIG, {r[31:8], 8'h8F}, 4'h1);
      wb(1'b0, `REG_CONFIG, 32'h0000_0000, 4'hF);
      check("config", 32'h0000_138F, rd);
      check("gainCode", 32'h8, 32'(gainCode));
      check("refSelect", 32'h1, 32'(refSelect));
      push(11, 32'h0020_C0CB, expData(16'h0040, 3));
      wb(1'b1, `REG_CONTROL, 32'h0000_0003, 4'h1);
      wait_empty;
      check("resolution14", 32'h1, 32'(resolution14));
      end_of_test;
   end
endmodule
